/* File: capture_timer.sv */
// Sixteen bit timer with input capture and byte-wide register access
// Functional notes
// - Normal mode counts up, wraps to zero
// - Overflow flag set when count wraps from maximum to zero
// - Clear-on-match mode clears after capture match
// - TOP unbuffered; low TOP wraps via maximum
// - TOP mode sets capture flag at TOP
// - Capture copies count and sets flag together
// - Every capture overwrites the capture register
// - Edge select: zero falling, one rising
// - Filter needs four equal samples
// - TOP mode disconnects the capture pin
// - Clock select: stop, io, ext fall, rise
// - External pin clocks even as output
// - Shared high-byte latch for 16-bit access
// - Counter write blocks next match
// - Interrupt needs enable, global flag, flag
// - Flags clear on vector or write-one
// - Reserved mask and flag bits read zero
// - CPU counter write beats clear or count
// - Low byte read loads latch; high first
`timescale 1ns/1ps
module capture_timer
  import capture_timer_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       reset_n_i,
  // CPU I/O bus
  input  wire logic [2:0] io_addr_i,
  input  wire logic       io_wr_i,
  input  wire logic       io_rd_i,
  input  wire logic [7:0] io_wdata_i,
  output logic      [7:0] io_rdata_o,
  // Interrupt handshake
  input  wire logic       global_irq_en_i,
  input  wire logic       capture_ack_i,
  input  wire logic       overflow_ack_i,
  output logic            capture_irq_o,
  output logic            overflow_irq_o,
  // Pins
  input  wire logic       capture_pin_i,
  input  wire logic       ext_count_pin_i
);

  //////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [7:0]  timer_ctrl_b;
  logic [15:0] counter_reg;
  logic [15:0] capture_reg;
  logic [7:0]  timer_irq_mask;
  logic        capture_flag;
  logic        overflow_flag;
  logic [7:0]  high_latch;
  logic        block_match;
  logic        ext_prev;
  logic        cap_prev;
  logic        cap_level;

  logic        capture_filter_en;
  logic        capture_edge_sel;
  logic        waveform_mode_bit;
  logic [2:0]  clock_sel;
  logic        capture_irq_en;
  logic        overflow_irq_en;

  assign capture_filter_en = timer_ctrl_b[FILTER_BIT];
  assign capture_edge_sel  = timer_ctrl_b[EDGE_BIT];
  assign waveform_mode_bit = timer_ctrl_b[MODE_BIT];
  assign clock_sel         = timer_ctrl_b[CLKSEL_MSB:0];
  assign capture_irq_en    = timer_irq_mask[CAPTURE_BIT];
  assign overflow_irq_en   = timer_irq_mask[OVERFLOW_BIT];

  logic wr_ctrl, wr_cnt_lo, wr_cnt_hi, wr_cap_lo, wr_cap_hi, wr_mask, wr_flags;
  logic rd_cnt_lo, rd_cap_lo;

  assign wr_ctrl   = io_wr_i && io_addr_i == ADDR_CTRL_B;
  assign wr_cnt_lo = io_wr_i && io_addr_i == ADDR_COUNT_LO;
  assign wr_cnt_hi = io_wr_i && io_addr_i == ADDR_COUNT_HI;
  assign wr_cap_lo = io_wr_i && io_addr_i == ADDR_CAPTURE_LO;
  assign wr_cap_hi = io_wr_i && io_addr_i == ADDR_CAPTURE_HI;
  assign wr_mask   = io_wr_i && io_addr_i == ADDR_IRQ_MASK;
  assign wr_flags  = io_wr_i && io_addr_i == ADDR_IRQ_FLAGS;
  assign rd_cnt_lo = io_rd_i && io_addr_i == ADDR_COUNT_LO;
  assign rd_cap_lo = io_rd_i && io_addr_i == ADDR_CAPTURE_LO;

  //////////////////////////////////////////////////////////////////////////////
  // Timer clock generation

  logic tick;

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ext_prev <= 1'b0;
    end else begin
      ext_prev <= ext_count_pin_i;
    end
  end

  // Pin is read regardless of its port direction
  always_comb begin
    case (clock_sel)
      CLK_STOP:     tick = 1'b0;
      CLK_IO:       tick = 1'b1;
      CLK_EXT_FALL: tick = ext_prev && !ext_count_pin_i;
      CLK_EXT_RISE: tick = !ext_prev && ext_count_pin_i;
      default:      tick = 1'b0;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Counter

  logic        top_match;
  logic [15:0] next_count;

  assign top_match  = waveform_mode_bit && counter_reg == capture_reg && !block_match;
  assign next_count = top_match ? COUNT_BOTTOM : counter_reg + 16'h0001;

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      counter_reg <= COUNT_BOTTOM;
    end else if (wr_cnt_lo) begin
      counter_reg <= {high_latch, io_wdata_i};
    end else if (tick) begin
      counter_reg <= next_count;
    end
  end

  // Counter write masks the match on the following timer clock
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      block_match <= 1'b0;
    end else if (wr_cnt_lo) begin
      block_match <= 1'b1;
    end else if (tick) begin
      block_match <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Capture input

  logic pin_gated;
  logic cap_event;

  assign pin_gated = capture_pin_i;

  capture_filter u_filter (
    .sys_clk_i (sys_clk_i),
    .reset_n_i (reset_n_i),
    .sample_i  (pin_gated),
    .enable_i  (capture_filter_en),
    .level_o   (cap_level)
  );

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cap_prev <= 1'b0;
    end else begin
      cap_prev <= cap_level;
    end
  end

  assign cap_event = !waveform_mode_bit &&
                     (capture_edge_sel ? (!cap_prev && cap_level) : (cap_prev && !cap_level));

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      capture_reg <= COUNT_BOTTOM;
    end else if (cap_event) begin
      capture_reg <= counter_reg;
    end else if (wr_cap_lo && waveform_mode_bit) begin
      capture_reg <= {high_latch, io_wdata_i};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Shared high-byte latch

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      high_latch <= 8'h00;
    end else if (wr_cnt_hi || wr_cap_hi) begin
      high_latch <= io_wdata_i;
    end else if (rd_cnt_lo) begin
      high_latch <= counter_reg[15:8];
    end else if (rd_cap_lo) begin
      high_latch <= capture_reg[15:8];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Control and mask

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      timer_ctrl_b <= CTRL_B_RESET;
    end else if (wr_ctrl) begin
      timer_ctrl_b <= io_wdata_i & CTRL_B_WMASK;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      timer_irq_mask <= 8'h00;
    end else if (wr_mask) begin
      timer_irq_mask <= io_wdata_i & IRQ_WMASK;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Flags

  logic ovf_set, cap_set;

  assign ovf_set = tick && next_count == COUNT_BOTTOM && counter_reg == COUNT_MAX && !wr_cnt_lo;
  assign cap_set = cap_event || (tick && top_match && !wr_cnt_lo);

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      overflow_flag <= 1'b0;
    end else if (ovf_set) begin
      overflow_flag <= 1'b1;
    end else if (overflow_ack_i || (wr_flags && io_wdata_i[OVERFLOW_BIT])) begin
      overflow_flag <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      capture_flag <= 1'b0;
    end else if (cap_set) begin
      capture_flag <= 1'b1;
    end else if (capture_ack_i || (wr_flags && io_wdata_i[CAPTURE_BIT])) begin
      capture_flag <= 1'b0;
    end
  end

  assign capture_irq_o  = capture_irq_en && global_irq_en_i && capture_flag;
  assign overflow_irq_o = overflow_irq_en && global_irq_en_i && overflow_flag;

  //////////////////////////////////////////////////////////////////////////////
  // Read data

  logic [7:0] flags_word;
  assign flags_word = {2'b00, capture_flag, 4'h0, overflow_flag};

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      io_rdata_o <= 8'h00;
    end else if (io_rd_i) begin
      case (io_addr_i)
        ADDR_CTRL_B:     io_rdata_o <= timer_ctrl_b;
        ADDR_COUNT_LO:   io_rdata_o <= counter_reg[7:0];
        ADDR_COUNT_HI:   io_rdata_o <= high_latch;
        ADDR_CAPTURE_LO: io_rdata_o <= capture_reg[7:0];
        ADDR_CAPTURE_HI: io_rdata_o <= high_latch;
        ADDR_IRQ_MASK:   io_rdata_o <= timer_irq_mask;
        ADDR_IRQ_FLAGS:  io_rdata_o <= flags_word;
        default:         io_rdata_o <= 8'h00;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Assertions

  AST_WRAP: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (tick && !wr_cnt_lo && !waveform_mode_bit && counter_reg == COUNT_MAX) |=> counter_reg == COUNT_BOTTOM)
    else $error("normal mode did not wrap");
  AST_OVF: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (tick && !wr_cnt_lo && counter_reg == COUNT_MAX) |=> overflow_flag)
    else $error("overflow flag missed");
  AST_CTC: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (tick && !wr_cnt_lo && top_match) |=> counter_reg == COUNT_BOTTOM && capture_flag)
    else $error("match clear missed");
  AST_NORMAL_UP: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (tick && !wr_cnt_lo && !waveform_mode_bit) |=> counter_reg == $past(counter_reg) + 16'h0001)
    else $error("normal mode did not increment");
  AST_CAPTURE: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    cap_event |=> capture_reg == $past(counter_reg) && capture_flag)
    else $error("capture copy wrong");
  AST_NO_PIN_TOP: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (waveform_mode_bit && !wr_cap_lo) |=> capture_reg == $past(capture_reg))
    else $error("pin capture in top mode");
  AST_CNT_WRITE: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    wr_cnt_lo |=> counter_reg == {$past(high_latch), $past(io_wdata_i)})
    else $error("counter write lost");
  AST_BLOCK: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    wr_cnt_lo ##1 (tick && !wr_cnt_lo && waveform_mode_bit) |=> counter_reg != COUNT_BOTTOM || $past(counter_reg) == COUNT_MAX)
    else $error("match not blocked after write");
  AST_IRQ: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    capture_irq_o |-> capture_flag && global_irq_en_i && timer_irq_mask[CAPTURE_BIT])
    else $error("spurious capture request");
  AST_SET_WINS: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (ovf_set && overflow_ack_i) |=> overflow_flag)
    else $error("clear beat set");
  AST_RES_ZERO: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    ($past(io_rd_i) && $past(io_addr_i) == ADDR_IRQ_FLAGS) |-> io_rdata_o[7:6] == 2'b00)
    else $error("reserved bits nonzero");

endmodule

/* File: capture_timer_pkg.sv */
// Constants for the sixteen bit capture timer
package capture_timer_pkg;

  // Register addresses on the 8-bit I/O bus
  localparam logic [2:0] ADDR_CTRL_B     = 3'h0;
  localparam logic [2:0] ADDR_COUNT_LO   = 3'h1;
  localparam logic [2:0] ADDR_COUNT_HI   = 3'h2;
  localparam logic [2:0] ADDR_CAPTURE_LO = 3'h3;
  localparam logic [2:0] ADDR_CAPTURE_HI = 3'h4;
  localparam logic [2:0] ADDR_IRQ_MASK   = 3'h5;
  localparam logic [2:0] ADDR_IRQ_FLAGS  = 3'h6;

  // Control register B fields
  localparam int FILTER_BIT   = 7;
  localparam int EDGE_BIT     = 6;
  localparam int MODE_BIT     = 4;
  localparam int CLKSEL_MSB   = 2;
  localparam logic [7:0] CTRL_B_WMASK = 8'hd7;
  localparam logic [7:0] CTRL_B_RESET = 8'h00;

  // Interrupt mask and flag fields
  localparam int CAPTURE_BIT  = 5;
  localparam int OVERFLOW_BIT = 0;
  localparam logic [7:0] IRQ_WMASK = 8'h21;

  // Clock select codes
  localparam logic [2:0] CLK_STOP    = 3'h0;
  localparam logic [2:0] CLK_IO      = 3'h1;
  localparam logic [2:0] CLK_EXT_FALL = 3'h6;
  localparam logic [2:0] CLK_EXT_RISE = 3'h7;

  // Counter limits
  localparam logic [15:0] COUNT_MAX    = 16'hffff;
  localparam logic [15:0] COUNT_BOTTOM = 16'h0000;

  // Filter needs this many equal samples
  localparam int FILTER_SAMPLES = 4;

endpackage

/* File: capture_filter.sv */
// Noise filter for the capture input
`timescale 1ns/1ps
module capture_filter
  import capture_timer_pkg::*;
(
  // Clock and reset
  input  wire logic sys_clk_i,
  input  wire logic reset_n_i,
  // Sample input and control
  input  wire logic sample_i,
  input  wire logic enable_i,
  // Filtered level
  output logic      level_o
);

  logic [FILTER_SAMPLES-1:0] history;
  logic                      filtered;

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      history <= '0;
    end else begin
      history <= {history[FILTER_SAMPLES-2:0], sample_i};
    end
  end

  // Output changes only once every sample agrees
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      filtered <= 1'b0;
    end else if (&history) begin
      filtered <= 1'b1;
    end else if (~|history) begin
      filtered <= 1'b0;
    end
  end

  assign level_o = enable_i ? filtered : sample_i;

endmodule

/* File: cpu_bus_model.sv */
// CPU model that reaches the timer registers over the byte-wide I/O bus
`timescale 1ns/1ps
module cpu_bus_model
  import capture_timer_pkg::*;
(
  // Clock
  input  wire logic       sys_clk_i,
  // I/O bus
  output logic      [2:0] io_addr_o,
  output logic            io_wr_o,
  output logic            io_rd_o,
  output logic      [7:0] io_wdata_o,
  input  wire logic [7:0] io_rdata_i
);
  initial begin
    io_addr_o = 3'h0;
    io_wr_o = 1'b0;
    io_rd_o = 1'b0;
    io_wdata_o = 8'h00;
  end

  task automatic wr8(input logic [2:0] addr, input logic [7:0] data);
    @(posedge sys_clk_i);
    #1;
    io_addr_o = addr;
    io_wdata_o = data;
    io_wr_o = 1'b1;
    @(posedge sys_clk_i);
    #1;
    io_wr_o = 1'b0;
    // Data is not held once the strobe drops
    io_wdata_o = ~data;
  endtask

  task automatic rd8(input logic [2:0] addr, output logic [7:0] data);
    @(posedge sys_clk_i);
    #1;
    io_addr_o = addr;
    io_rd_o = 1'b1;
    @(posedge sys_clk_i);
    #1;
    io_rd_o = 1'b0;
    data = io_rdata_i;
  endtask

  // High byte first so the low write commits the whole word
  task automatic wr16(input logic [2:0] lo, input logic [15:0] data);
    wr8(lo + 3'h1, data[15:8]);
    wr8(lo, data[7:0]);
  endtask

  // Low byte first so the latch holds the matching high byte
  task automatic rd16(input logic [2:0] lo, output logic [15:0] data);
    rd8(lo, data[7:0]);
    rd8(lo + 3'h1, data[15:8]);
  endtask
endmodule

/* File: sixteen_bit_capture_timer_test.sv */
// Self-checking bench for the sixteen bit capture timer
`timescale 1ns/1ps
module sixteen_bit_capture_timer_test;
  import capture_timer_pkg::*;
  logic       sys_clk = 1'b0;
  logic       reset_n = 1'b0;
  logic [2:0] io_addr;
  logic       io_wr;
  logic       io_rd;
  logic [7:0] io_wdata;
  logic [7:0] io_rdata;
  logic       glb_en = 1'b0;
  logic       cap_ack = 1'b0;
  logic       ovf_ack = 1'b0;
  logic       cap_irq;
  logic       ovf_irq;
  logic       cap_pin = 1'b0;
  logic       ext_pin = 1'b0;
  int         err_count = 0;
  int         tests_run = 0;

  always #25 sys_clk = ~sys_clk;

  cpu_bus_model cpu_u (.sys_clk_i(sys_clk), .io_addr_o(io_addr), .io_wr_o(io_wr), .io_rd_o(io_rd),
    .io_wdata_o(io_wdata), .io_rdata_i(io_rdata));

  capture_timer dut_u (.sys_clk_i(sys_clk), .reset_n_i(reset_n), .io_addr_i(io_addr), .io_wr_i(io_wr),
    .io_rd_i(io_rd), .io_wdata_i(io_wdata), .io_rdata_o(io_rdata), .global_irq_en_i(glb_en),
    .capture_ack_i(cap_ack), .overflow_ack_i(ovf_ack), .capture_irq_o(cap_irq), .overflow_irq_o(ovf_irq),
    .capture_pin_i(cap_pin), .ext_count_pin_i(ext_pin));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic results();
    if (err_count == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", name, exp, got);
      err_count++;
    end
  endtask

  task automatic rd8c(input logic [2:0] addr, input logic [7:0] exp, input string name);
    logic [7:0] b;
    cpu_u.rd8(addr, b);
    chk(name, {8'h00, exp}, {8'h00, b});
  endtask

  task automatic rd16c(input logic [2:0] lo, input logic [15:0] exp, input string name);
    logic [15:0] w;
    cpu_u.rd16(lo, w);
    chk(name, exp, w);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // Start the selected clock, let 22 ticks pass, then stop it
  task automatic run(input logic [7:0] ctrl);
    cpu_u.wr8(ADDR_CTRL_B, ctrl);
    repeat (20) @(posedge sys_clk);
    cpu_u.wr8(ADDR_CTRL_B, ctrl & 8'hf8);
  endtask

  task automatic ext_pulses(input int n);
    repeat (n) begin
      ext_pin = 1'b1;
      cyc(3);
      ext_pin = 1'b0;
      cyc(3);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    results();
  end

  initial begin
    repeat (5) @(posedge sys_clk);
    #1;
    reset_n = 1'b1;
    rd8c(ADDR_CTRL_B, CTRL_B_RESET, "ctrl_b");
    rd8c(ADDR_IRQ_FLAGS, 8'h00, "flags");
    cpu_u.wr8(ADDR_CTRL_B, 8'hff);
    rd8c(ADDR_CTRL_B, 8'hd7, "ctrl_b rsvd");
    cpu_u.wr8(ADDR_IRQ_MASK, 8'hff);
    rd8c(ADDR_IRQ_MASK, 8'h21, "mask rsvd");
    cpu_u.wr8(3'h7, 8'h5a);
    rd8c(3'h7, 8'h00, "unmapped");
    cpu_u.wr8(ADDR_CTRL_B, 8'h00);
    cpu_u.wr16(ADDR_COUNT_LO, 16'h1234);
    rd16c(ADDR_COUNT_LO, 16'h1234, "count rw");
    cpu_u.wr16(ADDR_CAPTURE_LO, 16'h0077);
    rd16c(ADDR_CAPTURE_LO, 16'h0000, "capture ro");
    // Normal mode wrap and overflow
    cpu_u.wr16(ADDR_COUNT_LO, 16'hfff0);
    run(8'h01);
    rd16c(ADDR_COUNT_LO, 16'h0006, "wrap");
    rd8c(ADDR_IRQ_FLAGS, 8'h21 & 8'h01, "overflow");
    glb_en = 1'b1;
    cyc(1);
    chk("ovf irq", 16'h1, {15'h0, ovf_irq});
    chk("cap irq", 16'h0, {15'h0, cap_irq});
    glb_en = 1'b0;
    cyc(1);
    chk("ovf irq off", 16'h0, {15'h0, ovf_irq});
    ovf_ack = 1'b1;
    cyc(1);
    ovf_ack = 1'b0;
    rd8c(ADDR_IRQ_FLAGS, 8'h00, "ovf ack");
    cpu_u.wr8(ADDR_CTRL_B, 8'h01);
    cpu_u.wr16(ADDR_COUNT_LO, 16'h0100);
    cpu_u.wr8(ADDR_CTRL_B, 8'h00);
    rd16c(ADDR_COUNT_LO, 16'h0102, "write wins");
    run(8'h03);
    rd16c(ADDR_COUNT_LO, 16'h0102, "reserved clk");
    // Clear-on-match mode
    cpu_u.wr8(ADDR_CTRL_B, 8'h10);
    cpu_u.wr16(ADDR_CAPTURE_LO, 16'h0005);
    cpu_u.wr16(ADDR_COUNT_LO, 16'h0005);
    cpu_u.wr8(ADDR_CTRL_B, 8'h11);
    cpu_u.wr8(ADDR_CTRL_B, 8'h10);
    rd16c(ADDR_COUNT_LO, 16'h0007, "match blocked");
    cpu_u.wr8(ADDR_IRQ_FLAGS, 8'h21);
    cpu_u.wr16(ADDR_COUNT_LO, 16'h0000);
    cap_pin = 1'b1;
    run(8'h11);
    cap_pin = 1'b0;
    cyc(5);
    rd16c(ADDR_COUNT_LO, 16'h0004, "ctc count");
    rd8c(ADDR_IRQ_FLAGS, 8'h20, "top flag");
    rd16c(ADDR_CAPTURE_LO, 16'h0005, "pin off");
    cpu_u.wr8(ADDR_IRQ_FLAGS, 8'h21);
    rd8c(ADDR_IRQ_FLAGS, 8'h00, "w1c");
    cpu_u.wr16(ADDR_COUNT_LO, 16'hfff0);
    run(8'h11);
    rd16c(ADDR_COUNT_LO, 16'h0000, "late top");
    rd8c(ADDR_IRQ_FLAGS, 8'h21, "late flags");
    // Pin captures in normal mode
    cpu_u.wr8(ADDR_CTRL_B, 8'h40);
    cpu_u.wr8(ADDR_IRQ_FLAGS, 8'h21);
    cpu_u.wr16(ADDR_COUNT_LO, 16'h0abc);
    cap_pin = 1'b1;
    cyc(5);
    rd16c(ADDR_CAPTURE_LO, 16'h0abc, "rise");
    rd8c(ADDR_IRQ_FLAGS, 8'h20, "cap flag");
    glb_en = 1'b1;
    cyc(1);
    chk("cap irq on", 16'h1, {15'h0, cap_irq});
    glb_en = 1'b0;
    cap_ack = 1'b1;
    cyc(1);
    cap_ack = 1'b0;
    cap_pin = 1'b0;
    cyc(5);
    rd8c(ADDR_IRQ_FLAGS, 8'h00, "no fall");
    cpu_u.wr8(ADDR_CTRL_B, 8'h00);
    cpu_u.wr16(ADDR_COUNT_LO, 16'h0222);
    cap_pin = 1'b1;
    cyc(5);
    cap_pin = 1'b0;
    cyc(5);
    rd16c(ADDR_CAPTURE_LO, 16'h0222, "fall");
    // Duty-cycle style: swap the edge right after the read, then clear the flag
    cpu_u.wr8(ADDR_CTRL_B, 8'h40);
    cpu_u.wr8(ADDR_IRQ_FLAGS, 8'h20);
    rd8c(ADDR_IRQ_FLAGS, 8'h00, "edge swap clear");
    cpu_u.wr8(ADDR_CTRL_B, 8'h80);
    cpu_u.wr16(ADDR_COUNT_LO, 16'h0444);
    cap_pin = 1'b1;
    cyc(10);
    cap_pin = 1'b0;
    cyc(2);
    cap_pin = 1'b1;
    cyc(10);
    rd16c(ADDR_CAPTURE_LO, 16'h0222, "glitch");
    cap_pin = 1'b0;
    cyc(10);
    rd16c(ADDR_CAPTURE_LO, 16'h0444, "filtered");
    // External count pin
    cpu_u.wr16(ADDR_COUNT_LO, 16'h0000);
    cpu_u.wr8(ADDR_CTRL_B, 8'h07);
    ext_pulses(3);
    cpu_u.wr8(ADDR_CTRL_B, 8'h06);
    ext_pulses(2);
    cpu_u.wr8(ADDR_CTRL_B, 8'h00);
    ext_pulses(1);
    rd16c(ADDR_COUNT_LO, 16'h0005, "ext count");
    // Overflow and vector acknowledge land on the same edge
    cpu_u.wr8(ADDR_IRQ_FLAGS, 8'h21);
    cpu_u.wr16(ADDR_COUNT_LO, 16'hffff);
    cpu_u.wr8(ADDR_CTRL_B, 8'h07);
    ext_pin = 1'b1;
    ovf_ack = 1'b1;
    cyc(1);
    ovf_ack = 1'b0;
    rd8c(ADDR_IRQ_FLAGS, 8'h01, "set wins");
    rd16c(ADDR_COUNT_LO, 16'h0000, "ext wrap");
    results();
  end
endmodule
